// ### core/idq_map.svh
// Register offsets, field positions, reset values and configuration constants of the DAQ port.
`ifndef IDQ_MAP_SVH
`define IDQ_MAP_SVH
`define IDQ_WIN_BYTES 16
`define IDQ_BASE_MIN 16'h0100
`define IDQ_OFS_DATA 4'h0
`define IDQ_OFS_CMD 4'h2
`define IDQ_OFS_CTRL 4'h4
`define IDQ_OFS_STAT 4'h6
`define IDQ_CTL_CLR_FIFO 0
`define IDQ_CTL_CLR_EXT 1
`define IDQ_CTL_CLR_CNT 2
`define IDQ_CTL_CLR_OVF 3
`define IDQ_CTL_CAL 4
`define IDQ_ST_AVAIL 0
`define IDQ_ST_OVF 1
`define IDQ_ST_PEND 2
`define IDQ_CMD_RST 10'h000
`define IDQ_CFG_ADDR_PORT 16'h0279
`define IDQ_CFG_DATA_PORT 16'h0A79
`define IDQ_KEY_SEED 8'h6A
`define IDQ_KEY_LEN 5'h1F
`define IDQ_CFG_CTRL 8'h02
`define IDQ_CFG_ACTIVE 8'h30
`define IDQ_CFG_BASE_HI 8'h60
`define IDQ_CFG_BASE_LO 8'h61
`define IDQ_CFG_IRQ 8'h70
`define IDQ_FIFO_DEPTH 9'h100
`endif

// ### core/idq_pkg.sv
// Types shared by the DAQ host port.
package idq_pkg;
  typedef logic [15:0] idq_word_t;
  typedef struct packed {
    logic cnt_en;
    logic fifo_en;
    logic ext_irq_source_enable;
    logic bipolar;
    logic [1:0] gain;
    logic [3:0] chan;
  } idq_cmd_s;
  typedef enum logic [1:0] {
    IDQ_WAIT_KEY = 2'h0,
    IDQ_CONFIG = 2'h1
  } idq_cfg_e;
endpackage

// ### core/idq_port.sv
// Host bus port of the DAQ card: configuration, decode, interrupt routing and result FIFO.
// Behaviour
// - Claim sixteen aligned consecutive I/O bytes.
// - Accept base 0x100 to 0xFFF0, 16-byte steps.
// - Board select when SA4-SA15 match base.
// - Decode SA0-SA3 with strobes into selects.
// - Steer data buffers by read or write.
// - Base and IRQ assigned by configuration protocol.
// - Interrupt on line 3,4,5,6,7 or 9 only.
// - Forward only enabled pending interrupt sources.
// - Data interrupt while FIFO holds words.
// - External interrupt while request input low.
// - Counter interrupt on counter output rise.
// - Separate enable and clear per source.
// - Store results in 16x256 FIFO.
// - Sign-extend 12-bit result to 16 bits.
// - Full FIFO plus new result flags overflow.
// - Data-available flag in status register.
// - Writable gain 0.5, 1, 2 plus polarity.
// - Channel select covers inputs 0 to 15.
// - Start converter calibration on command.
`timescale 1ns/1ps
`include "idq_map.svh"

module idq_port
  import idq_pkg::*;
(
  input wire logic core_clk_in, // 200 MHz clock
  input wire logic rst_b_in, // Asynchronous reset, active low
  input wire logic [15:0] addr_in, // Host address SA0-SA15
  input wire idq_word_t wdata_in, // Host write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output idq_word_t rdata_out, // Read data, cycle after strobe
  output logic buf_en_n_out, // Data buffer enable, low active
  output logic buf_to_host_out, // Data buffer points at host
  output logic [5:0] irq_out, // Request lines 3,4,5,6,7,9
  output logic [5:0] irq_oe_n_out, // Request line enables, low drives
  input wire logic adc_valid_in, // Conversion done pulse
  input wire logic [11:0] adc_data_in, // Conversion result
  input wire logic ext_irq_request_n_in, // External request, low active
  input wire logic cnt2_in, // Counter 2 output
  output logic [3:0] mux_chan_out, // Analog channel
  output logic [1:0] gain_sel_out, // 0: x0.5, 1: x1, 2: x2
  output logic bipolar_out, // Bipolar range
  output logic cal_start_out // Calibration start pulse
);

  idq_cfg_e cfg_r;
  logic [7:0] lfsr_r;
  logic [4:0] key_cnt_r;
  logic [7:0] cfg_idx_r;
  logic [15:0] base_r;
  logic [3:0] irq_lvl_r;
  logic active_r;
  idq_cmd_s cmd_r;
  logic [2:0] pend_r;
  logic ovf_r;
  logic cnt2_d_r;
  idq_word_t mem [0:255];
  logic [7:0] wp_r;
  logic [7:0] rp_r;
  logic [8:0] cnt_r;

  // Configuration protocol decode; only the key port is live while waiting for the key.
  wire cfg_addr_wr = wr_in && addr_in == `IDQ_CFG_ADDR_PORT;
  wire key_wr = cfg_addr_wr && cfg_r == IDQ_WAIT_KEY;
  wire key_hit = wdata_in[7:0] == lfsr_r;
  wire [7:0] lfsr_nxt = {lfsr_r[1] ^ lfsr_r[0], lfsr_r[7:1]};
  wire cfg_data_wr = wr_in && addr_in == `IDQ_CFG_DATA_PORT && cfg_r == IDQ_CONFIG;
  wire idx_wr = cfg_addr_wr && cfg_r == IDQ_CONFIG;
  wire cfg_ctrl_wr = cfg_data_wr && cfg_idx_r == `IDQ_CFG_CTRL;

  // Window decode.
  wire base_ok = active_r && base_r >= `IDQ_BASE_MIN;
  wire board_sel = base_ok && addr_in[15:4] == base_r[15:4];
  wire [3:0] ofs = addr_in[3:0];
  wire pop_req = board_sel && rd_in && ofs == `IDQ_OFS_DATA;
  wire cmd_wr = board_sel && wr_in && ofs == `IDQ_OFS_CMD;
  wire ctl_wr = board_sel && wr_in && ofs == `IDQ_OFS_CTRL;
  wire stat_rd = board_sel && rd_in && ofs == `IDQ_OFS_STAT;
  wire cmd_rd = board_sel && rd_in && ofs == `IDQ_OFS_CMD;

  // FIFO control.
  wire empty = cnt_r == 9'h000;
  wire full = cnt_r == `IDQ_FIFO_DEPTH;
  wire pop = pop_req && !empty;
  wire push = adc_valid_in && (!full || pop);
  wire ovf_set = adc_valid_in && full && !pop;
  wire idq_word_t head = mem[rp_r];
  wire idq_word_t ext_word = {{4{adc_data_in[11]}}, adc_data_in};
  wire [8:0] cnt_nxt = cnt_r + {8'h00, push} - {8'h00, pop};

  // Interrupt sources; hardware set wins over a software clear in the same cycle.
  wire [2:0] src_set = {cnt2_in && !cnt2_d_r, !ext_irq_request_n_in, !empty};
  wire [2:0] src_clr = {3{ctl_wr}} & wdata_in[`IDQ_CTL_CLR_CNT:`IDQ_CTL_CLR_FIFO];
  wire [2:0] src_en = {cmd_r.cnt_en, cmd_r.ext_irq_source_enable, cmd_r.fifo_en};
  wire irq_req = |(pend_r & src_en);
  wire ovf_clr = ctl_wr && wdata_in[`IDQ_CTL_CLR_OVF];

  // One-hot line select; an unsupported level selects no line at all.
  logic [5:0] irq_sel;
  always_comb begin
    case (irq_lvl_r)
      4'h3: irq_sel = 6'h01;
      4'h4: irq_sel = 6'h02;
      4'h5: irq_sel = 6'h04;
      4'h6: irq_sel = 6'h08;
      4'h7: irq_sel = 6'h10;
      4'h9: irq_sel = 6'h20;
      default: irq_sel = 6'h00;
    endcase
  end

  // An empty data read answers zero and moves no pointer, so no stale word reaches the host.
  wire idq_word_t stat_word = {11'h000, pend_r, ovf_r, !empty};
  wire idq_word_t rd_mux = pop ? head :
                           stat_rd ? stat_word :
                           cmd_rd ? {6'h00, cmd_r} : 16'h0000;

  // Gain code 3 has no meaning and falls back to unity.
  wire [1:0] gain_wr_sel = (wdata_in[5:4] == 2'h3) ? 2'h1 : wdata_in[5:4];

  // Key sequence and configuration registers.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_r <= IDQ_WAIT_KEY;
      lfsr_r <= `IDQ_KEY_SEED;
      key_cnt_r <= 5'h00;
    end else if (key_wr) begin
      lfsr_r <= key_hit ? lfsr_nxt : `IDQ_KEY_SEED;
      key_cnt_r <= key_hit ? key_cnt_r + 5'h01 : 5'h00;
      if (key_hit && key_cnt_r == `IDQ_KEY_LEN) begin
        cfg_r <= IDQ_CONFIG;
      end
    end else if (cfg_ctrl_wr && wdata_in[1]) begin
      cfg_r <= IDQ_WAIT_KEY;
      lfsr_r <= `IDQ_KEY_SEED;
      key_cnt_r <= 5'h00;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_idx_r <= 8'h00;
      base_r <= 16'h0000;
      irq_lvl_r <= 4'h0;
      active_r <= 1'b0;
    end else if (idx_wr) begin
      cfg_idx_r <= wdata_in[7:0];
    end else if (cfg_ctrl_wr && wdata_in[0]) begin
      base_r <= 16'h0000;
      irq_lvl_r <= 4'h0;
      active_r <= 1'b0;
    end else if (cfg_data_wr) begin
      case (cfg_idx_r)
        `IDQ_CFG_ACTIVE: active_r <= wdata_in[0];
        `IDQ_CFG_BASE_HI: base_r[15:8] <= wdata_in[7:0];
        `IDQ_CFG_BASE_LO: base_r[7:0] <= {wdata_in[7:4], 4'h0};
        `IDQ_CFG_IRQ: irq_lvl_r <= wdata_in[3:0];
        default: base_r <= base_r;
      endcase
    end
  end

  // Command register and front-end controls.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cmd_r <= `IDQ_CMD_RST;
      gain_sel_out <= 2'h0;
      cal_start_out <= 1'b0;
    end else begin
      if (cmd_wr) begin
        cmd_r <= wdata_in[9:0];
        gain_sel_out <= gain_wr_sel;
      end
      cal_start_out <= ctl_wr && wdata_in[`IDQ_CTL_CAL];
    end
  end

  assign mux_chan_out = cmd_r.chan;
  assign bipolar_out = cmd_r.bipolar;

  // Result FIFO.
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wp_r] <= ext_word;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_r <= 8'h00;
      rp_r <= 8'h00;
      cnt_r <= 9'h000;
      ovf_r <= 1'b0;
    end else begin
      wp_r <= wp_r + {7'h00, push};
      rp_r <= rp_r + {7'h00, pop};
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_set || (ovf_r && !ovf_clr);
    end
  end

  // Interrupt pending bits and line drive.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_r <= 3'h0;
      cnt2_d_r <= 1'b0;
      irq_out <= 6'h00;
      irq_oe_n_out <= 6'h3F;
    end else begin
      pend_r <= src_set | (pend_r & ~src_clr);
      cnt2_d_r <= cnt2_in;
      irq_out <= irq_sel & {6{irq_req}};
      irq_oe_n_out <= ~(irq_sel & {6{active_r}});
    end
  end

  // Bus answer and buffer steering; the buffer follows the strobe by one cycle, like the data.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 16'h0000;
      buf_en_n_out <= 1'b1;
      buf_to_host_out <= 1'b0;
    end else begin
      rdata_out <= rd_mux;
      buf_en_n_out <= !(board_sel && (rd_in || wr_in));
      buf_to_host_out <= board_sel && rd_in;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_OUTSIDE: assert property ((rd_in || wr_in) && addr_in[15:4] != base_r[15:4]
    |=> buf_en_n_out) else $error("Access outside window opened the buffers.");
  AST_BASE_LOW: assert property ((rd_in || wr_in) && base_r < `IDQ_BASE_MIN
    |=> buf_en_n_out) else $error("Base below minimum was decoded.");
  AST_RD_DIR: assert property (board_sel && rd_in
    |=> !buf_en_n_out && buf_to_host_out) else $error("Read did not steer buffer to host.");
  AST_WR_DIR: assert property (board_sel && wr_in
    |=> !buf_en_n_out && !buf_to_host_out) else $error("Write did not steer buffer to board.");
  AST_CMD_WR: assert property (cmd_wr
    |=> mux_chan_out == $past(wdata_in[3:0])) else $error("Channel select not written.");
  AST_ONE_LINE: assert property ($onehot0(~irq_oe_n_out))
    else $error("More than one request line driven.");
  AST_GATE: assert property (!irq_req |=> irq_out == 6'h00)
    else $error("Disabled source reached a request line.");
  AST_FIFO_PEND: assert property (!empty && ctl_wr
    |=> pend_r[0]) else $error("Data interrupt lost while FIFO holds data.");
  AST_EXT_PEND: assert property (!ext_irq_request_n_in |=> pend_r[1])
    else $error("External request not pending.");
  AST_CNT_PEND: assert property ($rose(cnt2_in) |=> pend_r[2])
    else $error("Counter rise not pending.");
  AST_SIGN: assert property (push |=> mem[$past(wp_r)][15:11] == {5{$past(adc_data_in[11])}})
    else $error("Result not sign-extended.");
  AST_OVF: assert property (ovf_set |=> ovf_r && cnt_r == `IDQ_FIFO_DEPTH)
    else $error("Overflow not flagged on full FIFO.");
  AST_OVF_HOLD: assert property (ovf_r && !ovf_clr |=> ovf_r)
    else $error("Overflow dropped without a clear.");
  AST_POP: assert property (pop |=> rdata_out == $past(head) && rp_r == $past(rp_r) + 8'h01)
    else $error("Data read did not return and remove oldest word.");
  AST_AVAIL: assert property (stat_rd |=> rdata_out[`IDQ_ST_AVAIL] == $past(!empty))
    else $error("Data-available flag wrong.");
  AST_CAL: assert property (ctl_wr && wdata_in[`IDQ_CTL_CAL] |=> cal_start_out)
    else $error("Calibration not started.");

  // Window, decode and buffer direction.
  AST_INACTIVE: assert property ((rd_in || wr_in) && !active_r
    |=> buf_en_n_out) else $error("Inactive board opened the buffers.");
  AST_ALIGN: assert property (base_r[3:0] == 4'h0)
    else $error("Base not on a sixteen-byte boundary.");
  AST_IDLE_BUF: assert property (!rd_in && !wr_in
    |=> buf_en_n_out) else $error("Buffers open without a strobe.");
  AST_DIR_IDLE: assert property (buf_en_n_out |-> !buf_to_host_out)
    else $error("Direction toward host while buffers disabled.");
  AST_ODD_OFS: assert property (board_sel && rd_in && ofs[0]
    |=> rdata_out == 16'h0000) else $error("Odd offset returned data.");
  AST_RD_ZERO: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("Read data stood past its cycle.");
  AST_CMD_RB: assert property (cmd_rd
    |=> rdata_out == {6'h00, $past(cmd_r)}) else $error("Command readback wrong.");

  // Configuration protocol.
  AST_KEY_ENTER: assert property (key_wr && key_hit && key_cnt_r == `IDQ_KEY_LEN
    |=> cfg_r == IDQ_CONFIG) else $error("Complete key did not open configuration.");
  AST_KEY_MISS: assert property (key_wr && !key_hit
    |=> key_cnt_r == 5'h00 && lfsr_r == `IDQ_KEY_SEED) else $error("Key not restarted.");
  AST_CFG_BASE: assert property (cfg_data_wr && cfg_idx_r == `IDQ_CFG_BASE_HI
    |=> base_r[15:8] == $past(wdata_in[7:0])) else $error("Base high byte not taken.");
  AST_IRQ_LVL: assert property (cfg_data_wr && cfg_idx_r == `IDQ_CFG_IRQ
    |=> irq_lvl_r == $past(wdata_in[3:0])) else $error("Interrupt level not taken.");
  AST_WAIT_LOCK: assert property (cfg_r == IDQ_WAIT_KEY
    |=> $stable(base_r) && $stable(active_r)) else $error("Resources changed before the key.");

  // Interrupt routing and pending bits.
  AST_NO_LINE: assert property (irq_sel == 6'h00
    |=> irq_out == 6'h00 && irq_oe_n_out == 6'h3F)
    else $error("Unsupported level drove a line.");
  AST_FWD: assert property (irq_req && irq_sel != 6'h00
    |=> irq_out == $past(irq_sel)) else $error("Enabled source not forwarded.");
  AST_OE_ACTIVE: assert property (!active_r |=> irq_oe_n_out == 6'h3F)
    else $error("Inactive board drove a request line.");
  AST_CLR_FIFO: assert property (src_clr[0] && empty |=> !pend_r[0])
    else $error("Data interrupt not cleared.");
  AST_CLR_EXT: assert property (src_clr[1] && ext_irq_request_n_in |=> !pend_r[1])
    else $error("External interrupt not cleared.");
  AST_CLR_CNT: assert property (src_clr[2] && !(cnt2_in && !cnt2_d_r) |=> !pend_r[2])
    else $error("Counter interrupt not cleared.");
  AST_PEND_HOLD: assert property (!ctl_wr |=> ($past(pend_r) & ~pend_r) == 3'h0)
    else $error("Pending bit dropped without a clear.");

  // Result FIFO and status.
  AST_COUNT: assert property (cnt_r <= `IDQ_FIFO_DEPTH)
    else $error("FIFO count beyond depth.");
  AST_PUSH_CNT: assert property (push && !pop |=> cnt_r == $past(cnt_r) + 9'h001)
    else $error("Stored result not counted.");
  AST_EMPTY_RD: assert property (pop_req && empty
    |=> rdata_out == 16'h0000 && rp_r == $past(rp_r)) else $error("Empty read returned data.");
  AST_OVF_CLR: assert property (ovf_clr && !ovf_set |=> !ovf_r)
    else $error("Overflow not cleared.");
  AST_OVF_STAT: assert property (stat_rd
    |=> rdata_out[`IDQ_ST_OVF] == $past(ovf_r)) else $error("Overflow flag not readable.");
  AST_PEND_STAT: assert property (stat_rd
    |=> rdata_out[`IDQ_ST_PEND + 2:`IDQ_ST_PEND] == $past(pend_r))
    else $error("Pending bits not readable.");

  // Front-end controls.
  AST_GAIN: assert property (cmd_wr && wdata_in[5:4] != 2'h3
    |=> gain_sel_out == $past(wdata_in[5:4]) && bipolar_out == $past(wdata_in[6]))
    else $error("Gain or polarity not taken.");
  AST_GAIN3: assert property (cmd_wr && wdata_in[5:4] == 2'h3
    |=> gain_sel_out == 2'h1) else $error("Gain code 3 not mapped to unity.");
  AST_CAL_ONLY: assert property (!(ctl_wr && wdata_in[`IDQ_CTL_CAL])
    |=> !cal_start_out) else $error("Calibration started without command.");

  COV_KEY: cover property (key_wr && key_hit && key_cnt_r == `IDQ_KEY_LEN);
  COV_POP: cover property (pop ##1 pop);
  COV_OVF: cover property (ovf_set);
  COV_IRQ: cover property (irq_req ##1 |irq_out);
  COV_CFG_OFF: cover property (cfg_ctrl_wr && wdata_in[0]);

endmodule

// ### tb/idq_adc_model.sv
// Behavioural converter that hands conversion results to the DAQ port.
`timescale 1ns/1ps
module idq_adc_model (
  input wire logic core_clk_in, // Board clock
  output logic adc_valid_out, // Conversion done pulse
  output logic [11:0] adc_data_out // Conversion result
);
  initial begin
    adc_valid_out = 1'b0;
    adc_data_out = 12'hA5A;
  end
  // The result bus is only meaningful with the pulse, so it is scrambled afterwards.
  task automatic convert(input logic [11:0] v);
    @(posedge core_clk_in);
    adc_valid_out <= 1'b1;
    adc_data_out <= v;
    @(posedge core_clk_in);
    adc_valid_out <= 1'b0;
    adc_data_out <= ~v;
  endtask
endmodule

// ### tb/idq_port_test.sv
// Self-checking testbench of the DAQ host port.
`timescale 1ns/1ps
`include "idq_map.svh"
module idq_port_test;
  import idq_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  idq_word_t wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic ext_irq_request_n_in = 1'b1;
  logic cnt2_in = 1'b0;
  idq_word_t rdata_out;
  logic buf_en_n_out, buf_to_host_out, adc_valid_in, bipolar_out, cal_start_out;
  logic [5:0] irq_out, irq_oe_n_out;
  logic [11:0] adc_data_in;
  logic [3:0] mux_chan_out;
  logic [1:0] gain_sel_out;
  int fails = 0;
  int samples_checked = 0;
  logic [15:0] seen;
  logic [7:0] key;
  logic bufn, tohost;
  always #2.5 core_clk_in = ~core_clk_in;
  idq_port idq_port_i (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .buf_en_n_out(buf_en_n_out), .buf_to_host_out(buf_to_host_out), .irq_out(irq_out),
    .irq_oe_n_out(irq_oe_n_out), .adc_valid_in(adc_valid_in), .adc_data_in(adc_data_in),
    .ext_irq_request_n_in(ext_irq_request_n_in), .cnt2_in(cnt2_in),
    .mux_chan_out(mux_chan_out), .gain_sel_out(gain_sel_out), .bipolar_out(bipolar_out),
    .cal_start_out(cal_start_out));
  idq_adc_model idq_adc_model_i (.core_clk_in(core_clk_in), .adc_valid_out(adc_valid_in),
    .adc_data_out(adc_data_in));
  function automatic logic [15:0] at(input logic [3:0] ofs);
    return {12'h030, ofs};
  endfunction
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    #1;
    bufn = buf_en_n_out;
    tohost = buf_to_host_out;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge core_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    seen = rdata_out;
    bufn = buf_en_n_out;
    tohost = buf_to_host_out;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // The full run needs about 1200 cycles; the limit leaves a wide margin.
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    idle(5);
    chk("oe_rst", {10'h000, irq_oe_n_out}, 16'h003F);
    chk("buf_rst", {15'h0000, buf_en_n_out}, 16'h0001);
    @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd(at(`IDQ_OFS_STAT));
    chk("pre_cfg", seen, 16'h0000);
    key = `IDQ_KEY_SEED;
    for (int i = 0; i < 32; i++) begin
      wr(`IDQ_CFG_ADDR_PORT, {8'h00, key});
      key = {key[1] ^ key[0], key[7:1]};
    end
    wr(`IDQ_CFG_ADDR_PORT, 16'h0060);
    wr(`IDQ_CFG_DATA_PORT, 16'h0003);
    wr(`IDQ_CFG_ADDR_PORT, 16'h0061);
    wr(`IDQ_CFG_DATA_PORT, 16'h0000);
    wr(`IDQ_CFG_ADDR_PORT, 16'h0070);
    wr(`IDQ_CFG_DATA_PORT, 16'h0005);
    wr(`IDQ_CFG_ADDR_PORT, 16'h0030);
    wr(`IDQ_CFG_DATA_PORT, 16'h0001);
    wr(at(`IDQ_OFS_CMD), 16'h0065);
    chk("wr_dir", {14'h0000, bufn, tohost}, 16'h0000);
    chk("chan", {8'h00, mux_chan_out, 1'b0, bipolar_out, gain_sel_out}, 16'h0056);
    rd(at(`IDQ_OFS_CMD));
    chk("cmd_rb", seen, 16'h0065);
    chk("rd_dir", {14'h0000, bufn, tohost}, 16'h0001);
    rd(16'h0316);
    chk("out_win", {seen[14:0], bufn}, 16'h0001);
    idq_adc_model_i.convert(12'hFFF);
    idle(3);
    chk("masked", {10'h000, irq_out}, 16'h0000);
    rd(at(`IDQ_OFS_STAT));
    chk("stat_av", seen, 16'h0005);
    wr(at(`IDQ_OFS_CMD), 16'h0165);
    idle(3);
    chk("irq_fifo", {2'h0, irq_oe_n_out, 2'h0, irq_out}, 16'h3B04);
    rd(at(`IDQ_OFS_DATA));
    chk("sext", seen, 16'hFFFF);
    wr(at(`IDQ_OFS_CTRL), 16'h0001);
    idle(3);
    chk("irq_clr", {10'h000, irq_out}, 16'h0000);
    for (int i = 0; i < 256; i++) idq_adc_model_i.convert({4'h8, i[7:0]});
    idq_adc_model_i.convert(12'h7FF);
    idle(2);
    rd(at(`IDQ_OFS_STAT));
    chk("ovf", seen, 16'h0007);
    for (int i = 0; i < 256; i++) begin
      rd(at(`IDQ_OFS_DATA));
      chk("fifo_word", seen, {8'hF8, i[7:0]});
      if (i == 1) begin
        rd(at(`IDQ_OFS_STAT));
        chk("ovf_hold", {14'h0000, seen[1:0]}, 16'h0003);
        wr(at(`IDQ_OFS_CTRL), 16'h0008);
        rd(at(`IDQ_OFS_STAT));
        chk("ovf_clr", {14'h0000, seen[1:0]}, 16'h0001);
      end
    end
    rd(at(`IDQ_OFS_DATA));
    chk("empty", seen, 16'h0000);
    rd(at(`IDQ_OFS_STAT));
    chk("no_av", {15'h0000, seen[0]}, 16'h0000);
    wr(at(`IDQ_OFS_CMD), 16'h0080);
    @(posedge core_clk_in);
    ext_irq_request_n_in <= 1'b0;
    idle(4);
    chk("irq_ext", {10'h000, irq_out}, 16'h0004);
    @(posedge core_clk_in);
    ext_irq_request_n_in <= 1'b1;
    wr(at(`IDQ_OFS_CTRL), 16'h0002);
    idle(3);
    chk("ext_clr", {10'h000, irq_out}, 16'h0000);
    wr(at(`IDQ_OFS_CMD), 16'h0200);
    @(posedge core_clk_in);
    cnt2_in <= 1'b1;
    idle(4);
    chk("irq_cnt", {10'h000, irq_out}, 16'h0004);
    wr(at(`IDQ_OFS_CTRL), 16'h0004);
    idle(3);
    chk("cnt_clr", {10'h000, irq_out}, 16'h0000);
    wr(at(`IDQ_OFS_CTRL), 16'h0010);
    chk("cal", {15'h0000, cal_start_out}, 16'h0001);
    idle(1);
    chk("cal_end", {15'h0000, cal_start_out}, 16'h0000);
    wr(at(`IDQ_OFS_CMD), 16'h0030);
    chk("gain3", {14'h0000, gain_sel_out}, 16'h0001);
    idq_adc_model_i.convert(12'h7FF);
    idle(1);
    rd(at(`IDQ_OFS_DATA));
    chk("unipolar", seen, 16'h07FF);
    wr(`IDQ_CFG_ADDR_PORT, 16'h0002);
    wr(`IDQ_CFG_DATA_PORT, 16'h0003);
    rd(at(`IDQ_OFS_STAT));
    chk("cfg_off", {seen[14:0], bufn}, 16'h0001);
    chk("oe_off", {10'h000, irq_oe_n_out}, 16'h003F);
    close_out();
  end
endmodule
